// ===== src/fdshadow_pkg.sv
// Purpose: constants and carriers for the floppy shadow and force-change block
// Assumes: one system clock, synchronous active-high reset
// Notes: index values are the shadow index numbers seen by the system side
package fdshadow_pkg;
    // shadow index numbers
    localparam logic [7:0] IDX_FORCE_CHANGE = 8'h99;
    localparam logic [7:0] IDX_RATE_SHADOW = 8'h9a;
    // reset values
    localparam logic [7:0] FORCE_CHANGE_RST = 8'h03;
    localparam logic [7:0] RATE_SHADOW_RST = 8'h00;
    // field positions
    localparam int RATE_LOW_MSB = 1;
    localparam int DIR_CHANGE_BIT = 7;

    // write strobes from the floppy register decode
    typedef struct packed {
        logic data_rate_wr;
        logic config_ctrl_wr;
        logic force_wr;
        logic [7:0] wdata;
    } fd_write_t;

    // index read port
    typedef struct packed {
        logic rd;
        logic [7:0] index;
    } idx_read_t;
endpackage : fdshadow_pkg

// ===== src/floppy_shadow_force_diskchange.sv
// Purpose: rate select shadow and sticky forced media change for floppy
// Assumes: inputs synchronous to clk_in; step pulse active low
// Notes: dir bit 7 and index read data are registered, one cycle late
`timescale 1ns/1ps

// How it works
// - rate or config write updates shadow bits 1:0
// - only rate write updates shadow bits 7:2
// - software sets force bits, zero never clears
// - step with select clears matching force bit
// - dir bit7 = gated force bits or change
// - both registers readable through index port
module floppy_shadow_force_diskchange
    import fdshadow_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // floppy register writes
    input wire logic data_rate_wr_in,
    input wire logic config_ctrl_wr_in,
    input wire logic [7:0] wdata_in,
    // index register port
    input wire logic idx_rd_in,
    input wire logic idx_wr_in,
    input wire logic [7:0] idx_in,
    output logic [7:0] idx_rdata_out,
    // drive interface
    input wire logic head_step_pulse_n_in,
    input wire logic drive_sel0_in,
    input wire logic drive_sel1_in,
    input wire logic media_change_input_in,
    // digital input register bit 7
    output logic dir_change_out
);
    // drive selects served by the sticky force bits
    localparam int NUM_DRIVES = 2;

    // request carriers
    fd_write_t wr;
    idx_read_t rdp;

    // rate select shadow register
    logic [7:0] rate_select_shadow_q;
    wire logic [7:0] rate_select_shadow_d;
    wire logic rate_low_load;
    wire logic rate_high_load;
    wire logic [RATE_LOW_MSB:0] rate_low_d;
    wire logic [7:RATE_LOW_MSB+1] rate_high_d;

    // sticky forced media change bits
    logic [NUM_DRIVES-1:0] forced_media_change_q;
    wire logic [NUM_DRIVES-1:0] forced_media_change_d;
    wire logic [NUM_DRIVES-1:0] force_set;
    wire logic [NUM_DRIVES-1:0] step_clr;
    wire logic [NUM_DRIVES-1:0] sel;
    wire logic [NUM_DRIVES-1:0] force_gated;
    wire logic step_act;

    // index decode and read data
    wire logic hit_force;
    wire logic hit_rate;
    wire logic [7:0] force_rdata;
    wire logic [7:0] idx_rdata_d;

    // digital input register bit 7
    wire logic dir_change_d;

    assign wr.data_rate_wr = data_rate_wr_in;
    assign wr.config_ctrl_wr = config_ctrl_wr_in;
    // only the force index takes writes; the shadow index is read-only
    assign wr.force_wr = idx_wr_in && (idx_in == IDX_FORCE_CHANGE);
    assign wr.wdata = wdata_in;
    assign rdp.rd = idx_rd_in;
    assign rdp.index = idx_in;

    // low rate bits follow both writes, the rest only the rate write
    assign rate_low_load = wr.data_rate_wr || wr.config_ctrl_wr;
    assign rate_high_load = wr.data_rate_wr;
    assign rate_low_d = rate_low_load
        ? wr.wdata[RATE_LOW_MSB:0]
        : rate_select_shadow_q[RATE_LOW_MSB:0];
    assign rate_high_d = rate_high_load
        ? wr.wdata[7:RATE_LOW_MSB+1]
        : rate_select_shadow_q[7:RATE_LOW_MSB+1];
    assign rate_select_shadow_d = {rate_high_d, rate_low_d};

    assign sel = {drive_sel1_in, drive_sel0_in};
    // step is a level: a held step keeps clearing
    assign step_act = ~head_step_pulse_n_in;

    for (genvar i = 0; i < NUM_DRIVES; i++) begin : g_force
        // a written one sets, a written zero leaves the bit alone
        assign force_set[i] = wr.force_wr && wr.wdata[i];
        assign step_clr[i] = step_act && sel[i];
        // set wins over a step clear in the same cycle
        assign forced_media_change_d[i] = force_set[i]
            || (forced_media_change_q[i] && !step_clr[i]);
        assign force_gated[i] = forced_media_change_q[i] && sel[i];
    end

    assign dir_change_d = (|force_gated) || media_change_input_in;

    assign hit_force = rdp.index == IDX_FORCE_CHANGE;
    assign hit_rate = rdp.index == IDX_RATE_SHADOW;
    assign force_rdata = {{(8-NUM_DRIVES){1'b0}}, forced_media_change_q};
    // read data holds between reads; unmapped indexes read zero
    assign idx_rdata_d = !rdp.rd ? idx_rdata_out
        : hit_rate ? rate_select_shadow_q
        : hit_force ? force_rdata
        : 8'h00;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rate_select_shadow_q <= RATE_SHADOW_RST;
        end else begin
            rate_select_shadow_q <= rate_select_shadow_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            forced_media_change_q <= FORCE_CHANGE_RST[NUM_DRIVES-1:0];
        end else begin
            forced_media_change_q <= forced_media_change_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            idx_rdata_out <= 8'h00;
            dir_change_out <= 1'b0;
        end else begin
            idx_rdata_out <= idx_rdata_d;
            dir_change_out <= dir_change_d;
        end
    end

    // checks
    property p_rate_low;
        @(posedge clk_in) disable iff (rst_in)
        config_ctrl_wr_in || data_rate_wr_in |=>
            rate_select_shadow_q[1:0] == $past(wdata_in[1:0]);
    endproperty
    a_rate_low: assert property (p_rate_low) else $error("low bits");

    property p_rate_load_high;
        @(posedge clk_in) disable iff (rst_in)
        data_rate_wr_in |=>
            rate_select_shadow_q[7:2] == $past(wdata_in[7:2]);
    endproperty
    a_rate_load_high: assert property (p_rate_load_high)
        else $error("high bits not loaded");

    property p_rate_high;
        @(posedge clk_in) disable iff (rst_in)
        !data_rate_wr_in |=>
            rate_select_shadow_q[7:2] == $past(rate_select_shadow_q[7:2]);
    endproperty
    a_rate_high: assert property (p_rate_high) else $error("high bits");

    property p_no_soft_clear;
        @(posedge clk_in) disable iff (rst_in)
        forced_media_change_q[0] && !step_clr[0] |=>
            forced_media_change_q[0];
    endproperty
    a_no_soft_clear: assert property (p_no_soft_clear)
        else $error("force cleared");

    property p_no_soft_clear1;
        @(posedge clk_in) disable iff (rst_in)
        forced_media_change_q[1] && !step_clr[1] |=>
            forced_media_change_q[1];
    endproperty
    a_no_soft_clear1: assert property (p_no_soft_clear1)
        else $error("force bit one cleared");

    property p_soft_set0;
        @(posedge clk_in) disable iff (rst_in)
        force_set[0] |=> forced_media_change_q[0];
    endproperty
    a_soft_set0: assert property (p_soft_set0)
        else $error("force bit zero not set");

    property p_soft_set1;
        @(posedge clk_in) disable iff (rst_in)
        force_set[1] |=> forced_media_change_q[1];
    endproperty
    a_soft_set1: assert property (p_soft_set1)
        else $error("force bit one not set");

    property p_step_clear;
        @(posedge clk_in) disable iff (rst_in)
        step_clr[1] && !force_set[1] |=> !forced_media_change_q[1];
    endproperty
    a_step_clear: assert property (p_step_clear)
        else $error("no clear");

    property p_step_clear0;
        @(posedge clk_in) disable iff (rst_in)
        step_clr[0] && !force_set[0] |=> !forced_media_change_q[0];
    endproperty
    a_step_clear0: assert property (p_step_clear0)
        else $error("no clear of bit zero");

    property p_dir;
        @(posedge clk_in) disable iff (rst_in)
        media_change_input_in |=> dir_change_out;
    endproperty
    a_dir: assert property (p_dir) else $error("dir bit");

    property p_dir_force;
        @(posedge clk_in) disable iff (rst_in)
        (forced_media_change_q[0] && drive_sel0_in)
            || (forced_media_change_q[1] && drive_sel1_in) |=>
            dir_change_out;
    endproperty
    a_dir_force: assert property (p_dir_force)
        else $error("dir bit not forced");

    property p_dir_quiet;
        @(posedge clk_in) disable iff (rst_in)
        !media_change_input_in
            && !(forced_media_change_q[0] && drive_sel0_in)
            && !(forced_media_change_q[1] && drive_sel1_in) |=>
            !dir_change_out;
    endproperty
    a_dir_quiet: assert property (p_dir_quiet)
        else $error("dir bit set without cause");

    property p_idx;
        @(posedge clk_in) disable iff (rst_in)
        idx_rd_in && idx_in == IDX_RATE_SHADOW |=>
            idx_rdata_out == $past(rate_select_shadow_q);
    endproperty
    a_idx: assert property (p_idx) else $error("index read");

    property p_idx_force;
        @(posedge clk_in) disable iff (rst_in)
        idx_rd_in && idx_in == IDX_FORCE_CHANGE |=>
            idx_rdata_out == $past(force_rdata);
    endproperty
    a_idx_force: assert property (p_idx_force)
        else $error("force index read");

    property p_idx_unmapped;
        @(posedge clk_in) disable iff (rst_in)
        idx_rd_in && idx_in != IDX_FORCE_CHANGE
            && idx_in != IDX_RATE_SHADOW |=>
            idx_rdata_out == 8'h00;
    endproperty
    a_idx_unmapped: assert property (p_idx_unmapped)
        else $error("unmapped index read");

    property p_idx_hold;
        @(posedge clk_in) disable iff (rst_in)
        !idx_rd_in |=> $stable(idx_rdata_out);
    endproperty
    a_idx_hold: assert property (p_idx_hold)
        else $error("read data moved");

    property p_ro;
        @(posedge clk_in) disable iff (rst_in)
        idx_wr_in && !data_rate_wr_in && !config_ctrl_wr_in |=>
            $stable(rate_select_shadow_q);
    endproperty
    a_ro: assert property (p_ro) else $error("shadow written");

    c_step: cover property (@(posedge clk_in)
        step_clr[0] && forced_media_change_q[0]);
    c_set: cover property (@(posedge clk_in) force_set[1]);
    c_dir: cover property (@(posedge clk_in) dir_change_out);
    c_set_on_step: cover property (@(posedge clk_in)
        force_set[0] && step_clr[0]);
    c_cfg_only: cover property (@(posedge clk_in)
        config_ctrl_wr_in && !data_rate_wr_in);
endmodule : floppy_shadow_force_diskchange

// ===== sim/drive_model.sv
// Purpose: drive side: step level, selects, media change
// Assumes: pattern bit 0 step, 1-2 selects, 3 change
// Notes: pass-through, bench owns the timing
`timescale 1ns/1ps
module drive_model (
    // pattern from bench
    input wire logic [3:0] pat_in,
    // drive lines
    output logic step_n_out,
    output logic sel0_out,
    output logic sel1_out,
    output logic change_out
);
    assign {change_out, sel1_out, sel0_out, step_n_out} = pat_in;
endmodule : drive_model

// ===== sim/tb_top.sv
// Purpose: self-checking bench with integer model
// Assumes: inputs change 1 ns after the rising edge
// Notes: random traffic from a 16-bit shift register
`timescale 1ns/1ps
module tb_top;
    import fdshadow_pkg::*;
    logic clk_in = 0, rst_in = 1, stn, s0, s1, chg, dir;
    fd_write_t wr = '0;
    idx_read_t rd = '0;
    logic [3:0] pat = 4'h1;
    logic [7:0] rdata;
    logic [15:0] lf = 16'h8190;
    int errors = 0, comparisons = 0, sh = 0, fc = 3, lr = 0, i;
    logic [7:0] exq[$];
    always #50 clk_in = ~clk_in;
    drive_model drv (.pat_in(pat), .step_n_out(stn), .sel0_out(s0),
        .sel1_out(s1), .change_out(chg));
    floppy_shadow_force_diskchange dut (.clk_in(clk_in), .rst_in(rst_in),
        .data_rate_wr_in(wr.data_rate_wr),
        .config_ctrl_wr_in(wr.config_ctrl_wr), .wdata_in(wr.wdata),
        .idx_rd_in(rd.rd), .idx_wr_in(wr.force_wr), .idx_in(rd.index),
        .idx_rdata_out(rdata), .head_step_pulse_n_in(stn),
        .drive_sel0_in(s0), .drive_sel1_in(s1),
        .media_change_input_in(chg), .dir_change_out(dir));
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : nxt
    task automatic chk8(input string nm, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask : chk8
    task automatic chk1(input logic e, g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("FAIL dir exp %b got %b", e, g);
        end
    endtask : chk1
    // one clock: drive, model, compare
    task automatic cyc(input logic [2:0] w, input logic [7:0] d, input logic r,
        input logic [7:0] ix, input logic [3:0] p);
        int er, ed;
        {wr.data_rate_wr, wr.config_ctrl_wr, wr.force_wr} = w;
        wr.wdata = d;
        rd = '{r, ix};
        pat = p;
        @(posedge clk_in);
        ed = (p[1] & fc[0]) | (p[2] & fc[1]) | p[3];
        er = ix == 8'h99 ? fc : ix == 8'h9a ? sh : 0;
        if (r) lr = er;
        exq.push_back(lr[7:0]);
        if (w[2]) sh = d;
        else if (w[1]) sh = (sh & 8'hfc) | (d & 8'h03);
        if (!p[0] && p[1]) fc &= 2;
        if (!p[0] && p[2]) fc &= 1;
        if (w[0] && ix == 8'h99) fc |= d & 8'h03;
        #1;
        chk1(ed[0], dir);
        chk8("rdata", exq.pop_front(), rdata);
    endtask : cyc
    task end_sim;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        #100000;
        errors++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge clk_in);
        #1 rst_in = 0;
        cyc(3'b000, 8'h00, 1, 8'h99, 4'h1);
        cyc(3'b100, 8'ha5, 1, 8'h9a, 4'h1);
        cyc(3'b010, 8'hfe, 1, 8'h9a, 4'h3);
        cyc(3'b001, 8'hff, 1, 8'h9a, 4'h5);
        cyc(3'b001, 8'h00, 1, 8'h99, 4'h7);
        cyc(3'b000, 8'h00, 1, 8'h99, 4'h2);
        cyc(3'b000, 8'h00, 1, 8'h99, 4'h4);
        cyc(3'b001, 8'h01, 1, 8'h99, 4'h8);
        for (i = 0; i < 400; i++) begin
            lf = nxt(lf);
            cyc(lf[2:0], lf[15:8], lf[3], 8'h99 + lf[5:4], lf[9:6]);
        end
        end_sim();
    end
endmodule : tb_top
